// ==== bench/fsfl_core_sva.sv ====
// Flag timing and echo clock checker
`timescale 1ns/100ps
module fsfl_core_sva
	import fsfl_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic [NFIFO-1:0] write_clock, // Write clocks
	input wire logic [NFIFO-1:0] read_clock, // Read clocks
	input wire logic flag_timing_select, // Timing mode
	input wire logic [NFIFO-1:0] full_flag_n, // Full
	input wire logic [NFIFO-1:0] almost_empty_n, // Almost empty
	input wire logic [NFIFO-1:0] almost_full_n, // Almost full
	input wire logic [NFIFO-1:0] echo_read_clock // Echo
);
	logic wc_q;
	logic rc_q;
	logic wc2_q;
	logic [4:0] wa_q;
	logic [4:0] ra_q;
	logic [4:0] wb_q;
	// Cycles since FIFO 0 clocks and FIFO 2 write clock rise, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wc_q <= 1'b0;
			rc_q <= 1'b0;
			wc2_q <= 1'b0;
			wa_q <= 5'h1F;
			ra_q <= 5'h1F;
			wb_q <= 5'h1F;
		end else begin
			wc_q <= write_clock[0];
			rc_q <= read_clock[0];
			wc2_q <= write_clock[2];
			wa_q <= (write_clock[0] & ~wc_q) ? 5'h00 : wa_q + {4'h0, ~&wa_q};
			ra_q <= (read_clock[0] & ~rc_q) ? 5'h00 : ra_q + {4'h0, ~&ra_q};
			wb_q <= (write_clock[2] & ~wc2_q) ? 5'h00 : wb_q + {4'h0, ~&wb_q};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_e0;
		$past(presetn, 3) |-> echo_read_clock[0] == $past(read_clock[0], 3);
	endproperty
	a_e0: assert property (p_e0) else $error("echo 0");
	property p_e2;
		$past(presetn, 3) |-> echo_read_clock[2] == $past(read_clock[2], 3);
	endproperty
	a_e2: assert property (p_e2) else $error("echo 2");
	property p_aes;
		flag_timing_select && $changed(almost_empty_n[0]) |-> ra_q <= 5'h06;
	endproperty
	a_aes: assert property (p_aes) else $error("ae sync");
	// Asynchronous flag timing is exercised on FIFO 2 only
	property p_aea;
		!flag_timing_select && $rose(almost_empty_n[2]) |-> wb_q <= 5'h06;
	endproperty
	a_aea: assert property (p_aea) else $error("ae async");
	property p_afs;
		flag_timing_select && $changed(almost_full_n[0]) |-> wa_q <= 5'h06;
	endproperty
	a_afs: assert property (p_afs) else $error("af sync");
	property p_afa;
		!flag_timing_select && $fell(almost_full_n[2]) |-> wb_q <= 5'h06;
	endproperty
	a_afa: assert property (p_afa) else $error("af async");
	property p_fr;
		$rose(full_flag_n[0]) |-> wa_q <= 5'h06;
	endproperty
	a_fr: assert property (p_fr) else $error("full rise");
	property p_ff;
		$fell(full_flag_n[0]) && almost_empty_n[0] |-> wa_q <= 5'h06;
	endproperty
	a_ff: assert property (p_ff) else $error("full fall");
	// The strap change after reset comes while almost-empty is still low
	property p_ir2;
		$changed(full_flag_n[2]) && almost_empty_n[2] |-> wb_q <= 5'h06;
	endproperty
	a_ir2: assert property (p_ir2) else $error("ready 2");
endmodule : fsfl_core_sva
bind fsfl_core fsfl_core_sva u_sva (.pclk, .presetn, .write_clock, .read_clock,
	.flag_timing_select, .full_flag_n, .almost_empty_n, .almost_full_n, .echo_read_clock);

// ==== bench/fsfl_partner.sv ====
// Writer and reader model beside the flag block
`timescale 1ns/100ps
module fsfl_partner
	import fsfl_pkg::*;
(
	input wire logic [NFIFO-1:0] wr_go, // Writers on
	input wire logic [NFIFO-1:0] rd_go, // Readers on
	input wire logic fall_thru, // Strap used
	input wire logic [NFIFO-1:0] full_flag_n, // Full
	output logic [NFIFO-1:0] write_clock, // Write clocks
	output logic [NFIFO-1:0] write_enable_n, // Write enables
	output logic [NFIFO-1:0] read_clock, // Read clocks
	output logic [NFIFO-1:0] read_enable_n, // Read enables
	output logic [NFIFO-1:0] read_chip_select_n // Read selects
);
	initial begin
		write_clock = 4'h0;
		write_enable_n = 4'hF;
		read_enable_n = 4'hF;
		read_chip_select_n = 4'hF;
		forever #80 write_clock = ~write_clock;
	end
	// Read phase offset keeps the two clocks' edges apart
	initial begin
		read_clock = 4'h0;
		#37;
		forever #80 read_clock = ~read_clock;
	end
	// Enables move on falling edges; writer stops once the flag says no room
	always @(negedge write_clock[0]) begin
		write_enable_n <= ~(wr_go & (fall_thru ? ~full_flag_n : full_flag_n));
	end
	always @(negedge read_clock[0]) begin
		read_enable_n <= ~rd_go;
		read_chip_select_n <= ~rd_go;
	end
endmodule : fsfl_partner

// ==== bench/tb_fsfl_core.sv ====
// Self-checking bench of the flag block
`timescale 1ns/100ps
module tb_fsfl_core;
	import fsfl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, sload_n, sdata;
	logic fts, fall_thru, dual;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NFIFO-1:0] wclk, wen_n, rclk, ren_n, rsel_n, wr_go, rd_go, full_n, ae_n, af_n;
	logic [CNT_W-1:0] fill [NFIFO];
	logic [CNT_W-1:0] ofs [2*NFIFO];
	logic [32:0] exp_q [$];
	int fails, samples_checked;
	fsfl_core u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .write_clock(wclk), .write_enable_n(wen_n), .read_clock(rclk),
		.read_enable_n(ren_n), .read_chip_select_n(rsel_n), .serial_clock(sclk),
		.serial_write_enable_n(sload_n), .mode_select_serial_in(sdata),
		.flag_timing_select(fts), .full_flag_n(full_n), .empty_flag_n(),
		.almost_empty_n(ae_n), .almost_full_n(af_n), .echo_read_clock());
	fsfl_partner u_far (.wr_go, .rd_go, .fall_thru, .full_flag_n(full_n), .write_clock(wclk),
		.write_enable_n(wen_n), .read_clock(rclk), .read_enable_n(ren_n),
		.read_chip_select_n(rsel_n));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [32:0] got, input logic [32:0] want);
		samples_checked++;
		if (got !== want) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
	end
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	function automatic logic [32:0] st();
		logic [32:0] s;
		logic [CNT_W-1:0] cap;
		s = 33'h0;
		cap = DEPTH + {10'h0, fall_thru};
		for (int i = 0; i < NFIFO; i++) begin
			s[ST_FULL_LSB+i] = fall_thru ? fill[i] == cap : fill[i] != cap;
			s[ST_EMPTY_LSB+i] = fill[i] != CNT_ZERO;
			s[ST_AE_LSB+i] = fall_thru ? fill[i] >= ofs[i] : fill[i] > ofs[i];
			s[ST_AF_LSB+i] = fill[i] < cap - ofs[NFIFO+i];
		end
		s[ST_FALL_THROUGH_MODE_BIT] = fall_thru;
		s[ST_PFM_BIT] = fts;
		return s;
	endfunction : st
	task automatic rst(input logic f, input logic t);
		presetn <= 1'b0;
		sdata <= f;
		fts <= t;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		fall_thru = f;
		dual = 1'b0;
		for (int i = 0; i < 2 * NFIFO; i++) ofs[i] = OFS_DEF;
		for (int i = 0; i < NFIFO; i++) fill[i] = CNT_ZERO;
		rd(ADDR_STATUS, st());
	endtask : rst
	task automatic burst(input logic r, input logic [NFIFO-1:0] m, input int k);
		@(posedge (r ? rclk[0] : wclk[0]));
		rd_go <= r ? m : 4'h0;
		wr_go <= r ? 4'h0 : m;
		repeat (k) @(posedge (r ? rclk[0] : wclk[0]));
		rd_go <= 4'h0;
		wr_go <= 4'h0;
		repeat (3) @(posedge wclk[0]);
		@(posedge pclk);
		for (int i = 0; i < NFIFO; i++) begin
			if (m[i] && !(dual && i[0])) fill[i] = r ? fill[i] - CNT_W'(k) : fill[i] + CNT_W'(k);
		end
	endtask : burst
	task automatic ser(input logic [CHAIN_W-1:0] v, input logic en_n);
		sload_n <= en_n;
		for (int i = CHAIN_W - 1; i >= 0; i--) begin
			sdata <= v[i];
			repeat (10) @(posedge pclk);
			sclk <= 1'b1;
			repeat (10) @(posedge pclk);
			sclk <= 1'b0;
		end
		sload_n <= 1'b1;
		for (int i = 0; i < 2 * NFIFO; i++) rd(ADDR_EOFS0 + ADDR_STEP * ADDR_W'(i), {22'h0, ofs[i]});
	endtask : ser
	// Walk one FIFO over each flag boundary, then free one word
	task automatic steps(input int f);
		logic [CNT_W-1:0] t [5];
		t[0] = ofs[f] - {10'h0, fall_thru};
		t[1] = t[0] + CNT_ONE;
		t[4] = DEPTH + {10'h0, fall_thru};
		t[3] = t[4] - ofs[NFIFO+f];
		t[2] = t[3] - CNT_ONE;
		for (int j = 0; j < 5; j++) begin
			burst(1'b0, 4'(1 << f), int'(t[j] - fill[f]));
			rd(ADDR_STATUS, st());
			rd(ADDR_FILL0 + ADDR_STEP * ADDR_W'(f), {22'h0, fill[f]});
		end
		burst(1'b1, 4'(1 << f), 1);
		rd(ADDR_STATUS, st());
	endtask : steps
	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		wrap_up();
	end
	initial begin
		logic [CHAIN_W-1:0] v;
		{presetn, psel, penable, pwrite, sclk, sdata, fts, fall_thru, dual} = 9'h0;
		{paddr, pwdata, wr_go, rd_go} = 52'h0;
		fails = 0;
		samples_checked = 0;
		sload_n = 1'b1;
		void'($urandom(32'hC68A));
		rst(1'b0, 1'b1);
		rd(ADDR_CTRL, 33'h0);
		rd(12'hFFC, {1'b1, 32'h0});
		$display("test reset done");
		apb(1'b1, ADDR_CTRL, 32'h1);
		dual = 1'b1;
		rd(ADDR_CTRL, 33'h1);
		burst(1'b0, 4'hF, 3);
		rd(ADDR_STATUS, st());
		apb(1'b1, ADDR_CTRL, 32'h0);
		dual = 1'b0;
		$display("test dual done");
		for (int i = 0; i < 2 * NFIFO; i++) begin
			ofs[i] = CNT_W'($urandom_range(60, 5));
			v[i*CNT_W +: CNT_W] = ofs[i];
		end
		ser(v, 1'b0);
		ser(~v, 1'b1);
		$display("test offsets done");
		steps(0);
		rst(1'b1, 1'b0);
		steps(2);
		$display("test fill done");
		wrap_up();
	end
endmodule : tb_fsfl_core

// ==== core/fsfl_core.sv ====
// Status flag, offset and echo clock logic for four FIFOs, with an APB register slave
//
// Contract
// - One full/input-ready flag per FIFO, four in quad mode, two in dual.
// - Mode pin level at reset picks full flags or input-ready flags.
// - Standard mode full flag goes low after the write filling last word.
// - Fall-through input-ready is low while space remains, high once filled.
// - Fall-through fill count includes output register word, one extra write.
// - Full flag follows write clock, two register stages, independent per FIFO.
// - Standard mode full flag returns high two write clocks after a read.
// - Fall-through input-ready returns low two write clocks after a read.
// - Almost-empty low at n words or fewer, n-1 in fall-through mode.
// - Separate empty offset and almost-empty flag for each of four FIFOs.
// - Flag timing pin high gives synchronous, low gives asynchronous almost flags.
// - Almost-empty sync on read clock; async set on read, clear on write.
// - Almost-full low after depth-m writes, depth+1-m in fall-through mode.
// - Separate full offset and almost-full flag for each of four FIFOs.
// - Almost-full sync on write clock; async set on write, clear on read.
// - One echo read clock per read port, independent, aligned to its data.
// - Echo clock free-runs, copying read clock regardless of enables.
// - Offsets shift in one bit per rising serial clock edge while enable low.
// - Empty flag low when FIFO empty, high when data available.
`timescale 1ns/100ps
module fsfl_core
	import fsfl_pkg::*;
(
	input wire logic pclk, // Block clock, 200 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic [ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [NFIFO-1:0] write_clock, // Write clock per FIFO
	input wire logic [NFIFO-1:0] write_enable_n, // Write enable per FIFO
	input wire logic [NFIFO-1:0] read_clock, // Read clock per FIFO
	input wire logic [NFIFO-1:0] read_enable_n, // Read enable per FIFO
	input wire logic [NFIFO-1:0] read_chip_select_n, // Read chip select per FIFO
	input wire logic serial_clock, // Offset load clock
	input wire logic serial_write_enable_n, // Offset load enable
	input wire logic mode_select_serial_in, // Mode strap and serial data
	input wire logic flag_timing_select, // High sync, low async almost flags
	output logic [NFIFO-1:0] full_flag_n, // Full, or input-ready in fall-through
	output logic [NFIFO-1:0] empty_flag_n, // Empty flag
	output logic [NFIFO-1:0] almost_empty_n, // Almost-empty flag
	output logic [NFIFO-1:0] almost_full_n, // Almost-full flag
	output logic [NFIFO-1:0] echo_read_clock // Echo of each read clock
);

	fsfl_state_t st_q;
	fsfl_state_t st_d;
	logic [SYN_W-1:0] raw_in;
	logic apb_access;
	logic addr_mapped;
	logic [31:0] rd_mux;

	assign raw_in = {flag_timing_select, mode_select_serial_in, serial_write_enable_n,
		serial_clock, read_chip_select_n, read_enable_n, read_clock, write_enable_n,
		write_clock};

	////////////////////////////////////////////////////////////////////////////////
	// Register read decode

	always_comb begin
		rd_mux = 32'h0000_0000;
		addr_mapped = 1'b1;
		case (paddr)
			ADDR_CTRL: rd_mux[CTRL_DUAL_BIT] = st_q.dual;
			ADDR_STATUS: begin
				rd_mux[ST_FULL_LSB +: NFIFO] = st_q.full_pin;
				rd_mux[ST_EMPTY_LSB +: NFIFO] = st_q.empty_n;
				rd_mux[ST_AE_LSB +: NFIFO] = st_q.ae_n;
				rd_mux[ST_AF_LSB +: NFIFO] = st_q.af_n;
				rd_mux[ST_FALL_THROUGH_MODE_BIT] = st_q.fall_through_mode;
				rd_mux[ST_PFM_BIT] = st_q.sync2[B_PFM];
			end
			default: begin
				addr_mapped = 1'b0;
				for (int k = 0; k < NFIFO; k++) begin
					if (paddr == ADDR_FILL0 + ADDR_STEP * k[ADDR_W-1:0]) begin
						rd_mux[CNT_W-1:0] = st_q.cnt[k];
						addr_mapped = 1'b1;
					end
					if (paddr == ADDR_EOFS0 + ADDR_STEP * k[ADDR_W-1:0]) begin
						rd_mux[CNT_W-1:0] = st_q.chain[k * CNT_W +: CNT_W];
						addr_mapped = 1'b1;
					end
					if (paddr == ADDR_FOFS0 + ADDR_STEP * k[ADDR_W-1:0]) begin
						rd_mux[CNT_W-1:0] = st_q.chain[(NFIFO + k) * CNT_W +: CNT_W];
						addr_mapped = 1'b1;
					end
				end
			end
		endcase
	end

	// Read data is captured in the setup cycle so prdata comes straight from a flop
	assign apb_access = psel & penable;
	assign pready = apb_access;
	assign pslverr = apb_access & ~addr_mapped;
	assign prdata = st_q.prdata;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic we;
		logic re;
		logic wr;
		logic rd;
		logic ae_c;
		logic af_c;
		logic [CNT_W-1:0] cap;
		logic [CNT_W-1:0] ncnt;
		logic [CNT_W-1:0] n_ofs;
		logic [CNT_W-1:0] m_ofs;
		we = 1'b0;
		re = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		ae_c = 1'b0;
		af_c = 1'b0;
		cap = DEPTH;
		ncnt = CNT_ZERO;
		n_ofs = CNT_ZERO;
		m_ofs = CNT_ZERO;
		st_d = st_q;

		// Only sync2 and prev are looked at; sync1 feeds sync2 alone
		st_d.sync1 = raw_in;
		st_d.sync2 = st_q.sync1;
		st_d.prev = st_q.sync2;

		// Strap is sampled once the synchroniser holds a settled value after reset
		if (!st_q.strap_done) begin
			if (st_q.strap_cnt == STRAP_WAIT) begin
				st_d.fall_through_mode = st_q.sync2[B_SI];
				st_d.strap_done = 1'b1;
			end else begin
				st_d.strap_cnt = st_q.strap_cnt + 2'h1;
			end
		end

		if (st_q.sync2[B_SCLK] && !st_q.prev[B_SCLK] && !st_q.sync2[B_SERIAL_WRITE_ENABLE_N]) begin
			st_d.chain = {st_q.chain[CHAIN_W-2:0], st_q.sync2[B_SI]};
		end

		if (apb_access && pwrite && paddr == ADDR_CTRL) begin
			st_d.dual = pwdata[CTRL_DUAL_BIT];
		end
		if (psel && !penable) begin
			st_d.prdata = rd_mux;
		end

		// Fall-through capacity counts the word held in the output register
		cap = st_q.fall_through_mode ? DEPTH + CNT_ONE : DEPTH;

		for (int i = 0; i < NFIFO; i++) begin
			we = st_q.sync2[B_WCLK + i] & ~st_q.prev[B_WCLK + i];
			re = st_q.sync2[B_RCLK + i] & ~st_q.prev[B_RCLK + i];
			n_ofs = st_q.chain[i * CNT_W +: CNT_W];
			m_ofs = st_q.chain[(NFIFO + i) * CNT_W +: CNT_W];
			// Writes past full are dropped, the writer is expected to stop
			wr = we & ~st_q.sync2[B_WEN + i] & (st_q.cnt[i] != cap);
			rd = re & ~st_q.sync2[B_REN + i] & ~st_q.sync2[B_RCS + i]
				& (st_q.cnt[i] != CNT_ZERO);
			ncnt = st_q.cnt[i];
			if (wr && !rd) begin
				ncnt = st_q.cnt[i] + CNT_ONE;
			end else if (rd && !wr) begin
				ncnt = st_q.cnt[i] - CNT_ONE;
			end
			st_d.cnt[i] = ncnt;

			// Filling shows on the same write edge; release passes the extra stage
			if (we) begin
				st_d.stage[i] = (ncnt == cap);
				st_d.full[i] = (ncnt == cap) | st_q.stage[i];
			end
			st_d.full_pin[i] = st_q.fall_through_mode ? st_d.full[i] : ~st_d.full[i];

			if (re) begin
				st_d.empty_n[i] = (ncnt != CNT_ZERO);
			end

			ae_c = st_q.fall_through_mode ? (ncnt < n_ofs) : (ncnt <= n_ofs);
			af_c = (ncnt >= cap - m_ofs);
			if (st_q.sync2[B_PFM]) begin
				if (re) begin
					st_d.ae_n[i] = ~ae_c;
				end
				if (we) begin
					st_d.af_n[i] = ~af_c;
				end
			end else begin
				// Assertion on its own clock wins over a release in the same cycle
				if (we && !ae_c) begin
					st_d.ae_n[i] = 1'b1;
				end
				if (re && ae_c) begin
					st_d.ae_n[i] = 1'b0;
				end
				if (re && !af_c) begin
					st_d.af_n[i] = 1'b1;
				end
				if (we && af_c) begin
					st_d.af_n[i] = 1'b0;
				end
			end

			st_d.echo[i] = st_q.sync2[B_RCLK + i];

			// Dual mode uses FIFOs 0 and 2; the others stay parked as empty
			if (st_q.dual && i[0]) begin
				st_d.cnt[i] = CNT_ZERO;
				st_d.full[i] = 1'b0;
				st_d.stage[i] = 1'b0;
				st_d.full_pin[i] = ~st_q.fall_through_mode;
				st_d.empty_n[i] = 1'b0;
				st_d.ae_n[i] = 1'b0;
				st_d.af_n[i] = 1'b1;
				st_d.echo[i] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign full_flag_n = st_q.full_pin;
	assign empty_flag_n = st_q.empty_n;
	assign almost_empty_n = st_q.ae_n;
	assign almost_full_n = st_q.af_n;
	assign echo_read_clock = st_q.echo;

endmodule : fsfl_core

// ==== core/fsfl_pkg.sv ====
// Constants, state layout and register map of the FIFO status flag block
package fsfl_pkg;

	localparam int NFIFO = 4;
	localparam int CNT_W = 11;
	localparam int CHAIN_W = 2 * NFIFO * CNT_W;
	// Depth per FIFO is a plain default; the fill count needs room for depth plus one
	localparam logic [CNT_W-1:0] DEPTH = 11'h400;
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
	localparam logic [CNT_W-1:0] OFS_DEF = 11'h07F;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	// Bit positions inside the synchroniser vector
	localparam int B_WCLK = 0;
	localparam int B_WEN = 4;
	localparam int B_RCLK = 8;
	localparam int B_REN = 12;
	localparam int B_RCS = 16;
	localparam int B_SCLK = 20;
	localparam int B_SERIAL_WRITE_ENABLE_N = 21;
	localparam int B_SI = 22;
	localparam int B_PFM = 23;
	localparam int SYN_W = 24;

	// Register map (byte addresses)
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_FILL0 = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_EOFS0 = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_FOFS0 = 12'h030;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h004;
	localparam int CTRL_DUAL_BIT = 0;
	localparam int ST_FULL_LSB = 0;
	localparam int ST_EMPTY_LSB = 4;
	localparam int ST_AE_LSB = 8;
	localparam int ST_AF_LSB = 12;
	localparam int ST_FALL_THROUGH_MODE_BIT = 16;
	localparam int ST_PFM_BIT = 17;
	localparam logic CTRL_DUAL_RST = 1'b0;

	typedef struct packed {
		logic [SYN_W-1:0] sync1;
		logic [SYN_W-1:0] sync2;
		logic [SYN_W-1:0] prev;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic fall_through_mode;
		logic dual;
		logic [CHAIN_W-1:0] chain;
		logic [NFIFO-1:0][CNT_W-1:0] cnt;
		logic [NFIFO-1:0] full;
		logic [NFIFO-1:0] stage;
		logic [NFIFO-1:0] full_pin;
		logic [NFIFO-1:0] empty_n;
		logic [NFIFO-1:0] ae_n;
		logic [NFIFO-1:0] af_n;
		logic [NFIFO-1:0] echo;
		logic [31:0] prdata;
	} fsfl_state_t;

	localparam fsfl_state_t ST_RESET = '{
		sync1: '0,
		sync2: '0,
		prev: '0,
		strap_cnt: 2'h0,
		strap_done: 1'b0,
		fall_through_mode: 1'b0,
		dual: CTRL_DUAL_RST,
		chain: {(2 * NFIFO){OFS_DEF}},
		cnt: '0,
		full: 4'h0,
		stage: 4'h0,
		full_pin: 4'hF,
		empty_n: 4'h0,
		ae_n: 4'h0,
		af_n: 4'hF,
		echo: 4'h0,
		prdata: 32'h0000_0000
	};

endpackage : fsfl_pkg
